// *** common/cbm_pkg.sv ***
// cache block maintenance unit: shared constants, register map and types
package cbm_pkg;
  localparam int ADDR_W  = 32;
  localparam int DATA_W  = 32;
  localparam int PADDR_W = 8;
  localparam int LINES   = 4;
  localparam int WORDS   = 4;
  localparam int IDX_W   = 2;
  localparam int WRD_W   = 2;
  localparam int IDX_LSB = 4;
  localparam int TAG_LSB = 6;
  localparam int TAG_W   = ADDR_W - TAG_LSB;
  localparam int BLK_W   = WORDS * DATA_W;
  localparam int OP_W    = 3;
  localparam int BCMD_W  = 3;

  // register byte offsets
  localparam logic [PADDR_W-1:0] REG_CMD    = 8'h00;
  localparam logic [PADDR_W-1:0] REG_ADDR   = 8'h04;
  localparam logic [PADDR_W-1:0] REG_STATUS = 8'h08;
  localparam logic [PADDR_W-1:0] REG_CFG    = 8'h0C;
  localparam logic [PADDR_W-1:0] REG_HIST   = 8'h10;
  localparam logic [PADDR_W-1:0] REG_PROBE  = 8'h14;
  localparam logic [PADDR_W-1:0] REG_PDATA  = 8'h18;
  localparam logic [PADDR_W-1:0] REG_PTAG   = 8'h1C;

  // command register fields
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_COH      = 4;
  localparam int CMD_CI       = 5;
  localparam int CMD_WT       = 6;
  localparam int CMD_DSTORE   = 7;
  localparam int CMD_LOAD_OK  = 8;
  localparam int CMD_STORE_OK = 9;

  // operation codes
  localparam logic [OP_W-1:0] OP_TOUCH    = 3'h0;
  localparam logic [OP_W-1:0] OP_TOUCH_ST = 3'h1;
  localparam logic [OP_W-1:0] OP_ZERO     = 3'h2;
  localparam logic [OP_W-1:0] OP_STORE    = 3'h3;
  localparam logic [OP_W-1:0] OP_FLUSH    = 3'h4;
  localparam logic [OP_W-1:0] OP_IINV     = 3'h5;
  localparam logic [OP_W-1:0] OP_ISYNC    = 3'h6;

  // far side commands
  localparam logic [BCMD_W-1:0] BUS_READ      = 3'h0;
  localparam logic [BCMD_W-1:0] BUS_WRITE     = 3'h1;
  localparam logic [BCMD_W-1:0] BUS_ZERO      = 3'h2;
  localparam logic [BCMD_W-1:0] BUS_SNP_CLEAN = 3'h3;
  localparam logic [BCMD_W-1:0] BUS_SNP_FLUSH = 3'h4;
  localparam logic [BCMD_W-1:0] BUS_SNP_KILL  = 3'h5;
  localparam logic [BCMD_W-1:0] BUS_SNP_IINV  = 3'h6;

  // status, config, history and probe fields
  localparam int STAT_BUSY  = 0;
  localparam int STAT_DONE  = 1;
  localparam int STAT_ALIGN = 2;
  localparam int STAT_DSI   = 3;
  localparam int STAT_NOOP  = 4;
  localparam int STAT_HIT   = 5;
  localparam int CFG_UNIFIED = 0;
  localparam int CFG_ZMEM    = 1;
  localparam int CFG_PF      = 2;
  localparam int HIST_REF = 0;
  localparam int HIST_CHG = 1;
  localparam int HIST_ST  = 2;
  localparam int PROBE_WRD_LSB = 0;
  localparam int PROBE_IDX_LSB = 2;
  localparam int PTAG_TAG_LSB = 0;
  localparam int PTAG_DV      = 28;
  localparam int PTAG_DM      = 29;
  localparam int PTAG_IV      = 30;

  typedef enum logic [2:0] {
    ST_IDLE, ST_EXEC, ST_WB, ST_FILL, ST_ZMEM, ST_FIN, ST_SNOOP, ST_SYNC
  } cbm_state_e;
endpackage

// *** verilog/cbm_unit.sv ***
// cache block maintenance unit with local cache directories and APB registers
//
// Overview of operation
// - ops whose address lies in a direct-store segment finish as no-ops.
// - touch ops never raise translation or protection exceptions; they are dropped.
// - touch is a hint; not load-accessible means nothing is done.
// - touch recorded in page history counts as a load.
// - block zero on a data cache hit clears every byte of the block.
// - block zero miss on cacheable page allocates without memory read, cleared.
// - block zero on inhibited or write-through zeroes memory or raises alignment.
// - coherent block zero keeps copies in other caches coherent.
// - block zero checks and records like a store to the addressed byte.
// - coherent block store writes back any modified copy anywhere.
// - non-coherent block store writes back only the local modified copy.
// - store, flush, instruction invalidate ignore write-through and inhibit attributes.
// - store, flush, instruction invalidate recorded as loads, never stores.
// - coherent flush local hit: write back if modified, invalidate everywhere.
// - coherent flush local miss: remote modified copies written back, all invalidated.
// - non-coherent flush invalidates local block after writeback; miss does nothing.
// - coherent instruction invalidate kills the block in all instruction caches.
// - non-coherent instruction invalidate kills only the local copy.
// - instruction invalidate not load-accessible raises a data storage exception.
// - unified cache: local no-op, remote invalidate still sent when coherent.
// - isync waits for earlier instructions; later ones held until it finishes.
// - isync discards prefetched instructions and leaves other processors alone.
// - caching-inhibited block zero bypasses the cache and goes to memory if cfg_zmem is set, else raises alignment; caching-inhibited touch skips the fill.
`timescale 1ns/10ps
`default_nettype none
module cbm_unit (
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [cbm_pkg::PADDR_W-1:0] paddr,
  input  wire logic [cbm_pkg::DATA_W-1:0]  pwdata,
  output logic      [cbm_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  output logic                             bus_req,
  output logic      [cbm_pkg::BCMD_W-1:0]  bus_cmd,
  output logic      [cbm_pkg::ADDR_W-1:0]  bus_addr,
  output logic      [cbm_pkg::BLK_W-1:0]   bus_wdata,
  input  wire logic [cbm_pkg::BLK_W-1:0]   bus_rdata,
  input  wire logic                        bus_ack,
  input  wire logic                        pipe_idle,
  output logic                             fetch_hold,
  output logic                             fetch_discard
);
  import cbm_pkg::*;

  typedef struct packed {
    cbm_state_e                              state;
    logic [OP_W-1:0]                         op;
    logic                                    coh;
    logic                                    ci;
    logic                                    wt;
    logic                                    dstore;
    logic                                    load_ok;
    logic                                    store_ok;
    logic [ADDR_W-1:0]                       ea;
    logic                                    cfg_unified;
    logic                                    cfg_zmem;
    logic                                    cfg_pf;
    logic                                    done;
    logic                                    exc_align;
    logic                                    exc_dsi;
    logic                                    noop;
    logic                                    hit;
    logic                                    ref_bit;
    logic                                    chg_bit;
    logic                                    hist_st;
    logic [IDX_W-1:0]                        probe_idx;
    logic [WRD_W-1:0]                        probe_wrd;
    logic [LINES-1:0]                        dvalid;
    logic [LINES-1:0]                        dmod;
    logic [LINES-1:0][TAG_W-1:0]             dtag;
    logic [LINES-1:0][WORDS-1:0][DATA_W-1:0] ddata;
    logic [LINES-1:0]                        ivalid;
    logic [LINES-1:0][TAG_W-1:0]             itag;
    logic                                    breq;
    logic [BCMD_W-1:0]                       bcmd;
    logic [ADDR_W-1:0]                       baddr;
    logic [BLK_W-1:0]                        bwdata;
    logic                                    discard;
    logic [DATA_W-1:0]                       rdata;
    logic                                    slverr;
  } cbm_st_s;

  cbm_st_s s;
  cbm_st_s next_s;

  function automatic logic [IDX_W-1:0] idx_of(input logic [ADDR_W-1:0] a);
    idx_of = a[IDX_LSB +: IDX_W];
  endfunction

  function automatic logic [TAG_W-1:0] tag_of(input logic [ADDR_W-1:0] a);
    tag_of = a[TAG_LSB +: TAG_W];
  endfunction

  function automatic logic [ADDR_W-1:0] blk_addr(input logic [TAG_W-1:0] t,
                                                 input logic [IDX_W-1:0] i);
    blk_addr = {t, i, {IDX_LSB{1'b0}}};
  endfunction

  // coherent ops that must be announced, and the announcement used
  function automatic logic [BCMD_W-1:0] snoop_cmd(input logic [OP_W-1:0] o);
    case (o)
      OP_ZERO:  snoop_cmd = BUS_SNP_KILL;
      OP_STORE: snoop_cmd = BUS_SNP_CLEAN;
      OP_FLUSH: snoop_cmd = BUS_SNP_FLUSH;
      default:  snoop_cmd = BUS_SNP_IINV;
    endcase
  endfunction

  function automatic logic needs_snoop(input logic [OP_W-1:0] o);
    needs_snoop = (o == OP_ZERO) || (o == OP_STORE) ||
                  (o == OP_FLUSH) || (o == OP_IINV);
  endfunction

  function automatic logic reg_mapped(input logic [PADDR_W-1:0] a);
    reg_mapped = (a == REG_CMD) || (a == REG_ADDR) || (a == REG_STATUS) ||
                 (a == REG_CFG) || (a == REG_HIST) || (a == REG_PROBE) ||
                 (a == REG_PDATA) || (a == REG_PTAG);
  endfunction

  logic [IDX_W-1:0] li;
  logic [TAG_W-1:0] tg;
  logic             dhit;
  logic             ihit;
  logic             victim_dirty;
  logic             setup;
  logic             wr;
  logic [ADDR_W-1:0] tgt_addr;

  always_comb begin
    next_s = s;
    next_s.discard = 1'b0;
    li = idx_of(s.ea);
    tg = tag_of(s.ea);
    tgt_addr = blk_addr(tg, li);
    dhit = s.dvalid[li] && (s.dtag[li] == tg);
    ihit = s.ivalid[li] && (s.itag[li] == tg);
    victim_dirty = s.dvalid[li] && s.dmod[li];
    setup = psel && !penable;
    wr = psel && penable && pwrite;

    // read data is caught in the setup phase so it leaves a flop
    if (setup) begin
      next_s.slverr = !reg_mapped(paddr);
      next_s.rdata = '0;
      case (paddr)
        REG_CMD: begin
          next_s.rdata[CMD_OP_LSB +: OP_W] = s.op;
          next_s.rdata[CMD_COH] = s.coh;
          next_s.rdata[CMD_CI] = s.ci;
          next_s.rdata[CMD_WT] = s.wt;
          next_s.rdata[CMD_DSTORE] = s.dstore;
          next_s.rdata[CMD_LOAD_OK] = s.load_ok;
          next_s.rdata[CMD_STORE_OK] = s.store_ok;
        end
        REG_ADDR: next_s.rdata = s.ea;
        REG_STATUS: begin
          next_s.rdata[STAT_BUSY] = (s.state != ST_IDLE);
          next_s.rdata[STAT_DONE] = s.done;
          next_s.rdata[STAT_ALIGN] = s.exc_align;
          next_s.rdata[STAT_DSI] = s.exc_dsi;
          next_s.rdata[STAT_NOOP] = s.noop;
          next_s.rdata[STAT_HIT] = s.hit;
        end
        REG_CFG: begin
          next_s.rdata[CFG_UNIFIED] = s.cfg_unified;
          next_s.rdata[CFG_ZMEM] = s.cfg_zmem;
          next_s.rdata[CFG_PF] = s.cfg_pf;
        end
        REG_HIST: begin
          next_s.rdata[HIST_REF] = s.ref_bit;
          next_s.rdata[HIST_CHG] = s.chg_bit;
          next_s.rdata[HIST_ST] = s.hist_st;
        end
        REG_PROBE: begin
          next_s.rdata[PROBE_WRD_LSB +: WRD_W] = s.probe_wrd;
          next_s.rdata[PROBE_IDX_LSB +: IDX_W] = s.probe_idx;
        end
        REG_PDATA: next_s.rdata = s.ddata[s.probe_idx][s.probe_wrd];
        REG_PTAG: begin
          next_s.rdata[PTAG_TAG_LSB +: TAG_W] = s.dtag[s.probe_idx];
          next_s.rdata[PTAG_DV] = s.dvalid[s.probe_idx];
          next_s.rdata[PTAG_DM] = s.dmod[s.probe_idx];
          next_s.rdata[PTAG_IV] = s.ivalid[s.probe_idx];
        end
        default: next_s.rdata = '0;
      endcase
    end

    // writes; command and address are ignored while an op runs
    if (wr) begin
      case (paddr)
        REG_CMD: if (s.state == ST_IDLE) begin
          next_s.op = pwdata[CMD_OP_LSB +: OP_W];
          next_s.coh = pwdata[CMD_COH];
          next_s.ci = pwdata[CMD_CI];
          next_s.wt = pwdata[CMD_WT];
          next_s.dstore = pwdata[CMD_DSTORE];
          next_s.load_ok = pwdata[CMD_LOAD_OK];
          next_s.store_ok = pwdata[CMD_STORE_OK];
          next_s.done = 1'b0;
          next_s.exc_align = 1'b0;
          next_s.exc_dsi = 1'b0;
          next_s.noop = 1'b0;
          next_s.state = ST_EXEC;
        end
        REG_ADDR: if (s.state == ST_IDLE) begin
          next_s.ea = pwdata;
        end
        REG_CFG: begin
          next_s.cfg_unified = pwdata[CFG_UNIFIED];
          next_s.cfg_zmem = pwdata[CFG_ZMEM];
          next_s.cfg_pf = pwdata[CFG_PF];
        end
        REG_HIST: begin
          // any write clears; a same-cycle set below still wins
          next_s.ref_bit = 1'b0;
          next_s.chg_bit = 1'b0;
        end
        REG_PROBE: begin
          next_s.probe_wrd = pwdata[PROBE_WRD_LSB +: WRD_W];
          next_s.probe_idx = pwdata[PROBE_IDX_LSB +: IDX_W];
        end
        default: ;
      endcase
    end

    unique case (s.state)
      ST_IDLE: ;
      ST_EXEC: begin
        next_s.hit = dhit;
        if (s.dstore) begin
          next_s.noop = 1'b1;
          next_s.done = 1'b1;
          next_s.state = ST_IDLE;
        end else begin
          case (s.op)
            OP_TOUCH, OP_TOUCH_ST: begin
              if (!s.load_ok) begin
                next_s.noop = 1'b1;
                next_s.done = 1'b1;
                next_s.state = ST_IDLE;
              end else begin
                next_s.ref_bit = 1'b1;
                next_s.hist_st = 1'b0;
                // a dirty victim is left alone: the hint may do nothing
                if (s.cfg_pf && !s.ci && !dhit && !victim_dirty) begin
                  next_s.breq = 1'b1;
                  next_s.bcmd = BUS_READ;
                  next_s.baddr = tgt_addr;
                  next_s.state = ST_FILL;
                end else begin
                  next_s.state = ST_FIN;
                end
              end
            end
            OP_ZERO: begin
              if (!s.store_ok) begin
                next_s.exc_dsi = 1'b1;
                next_s.done = 1'b1;
                next_s.state = ST_IDLE;
              end else begin
                next_s.ref_bit = 1'b1;
                next_s.chg_bit = 1'b1;
                next_s.hist_st = 1'b1;
                if (s.ci || s.wt) begin
                  if (s.cfg_zmem) begin
                    if (dhit && !s.ci) begin
                      next_s.ddata[li] = '0;
                    end
                    next_s.breq = 1'b1;
                    next_s.bcmd = BUS_ZERO;
                    next_s.baddr = tgt_addr;
                    next_s.state = ST_ZMEM;
                  end else begin
                    next_s.exc_align = 1'b1;
                    next_s.done = 1'b1;
                    next_s.state = ST_IDLE;
                  end
                end else if (dhit) begin
                  next_s.ddata[li] = '0;
                  next_s.dmod[li] = 1'b1;
                  next_s.state = ST_FIN;
                end else if (victim_dirty) begin
                  next_s.breq = 1'b1;
                  next_s.bcmd = BUS_WRITE;
                  next_s.baddr = blk_addr(s.dtag[li], li);
                  next_s.bwdata = s.ddata[li];
                  next_s.state = ST_WB;
                end else begin
                  next_s.dvalid[li] = 1'b1;
                  next_s.dtag[li] = tg;
                  next_s.ddata[li] = '0;
                  next_s.dmod[li] = 1'b1;
                  next_s.state = ST_FIN;
                end
              end
            end
            OP_STORE, OP_FLUSH: begin
              next_s.ref_bit = 1'b1;
              next_s.hist_st = 1'b0;
              // attributes ci and wt are deliberately not consulted
              if (dhit && s.dmod[li]) begin
                next_s.breq = 1'b1;
                next_s.bcmd = BUS_WRITE;
                next_s.baddr = tgt_addr;
                next_s.bwdata = s.ddata[li];
                next_s.state = ST_WB;
              end else begin
                if (dhit && (s.op == OP_FLUSH)) begin
                  next_s.dvalid[li] = 1'b0;
                end
                next_s.state = ST_FIN;
              end
            end
            OP_IINV: begin
              if (!s.load_ok) begin
                next_s.exc_dsi = 1'b1;
                next_s.done = 1'b1;
                next_s.state = ST_IDLE;
              end else begin
                next_s.ref_bit = 1'b1;
                next_s.hist_st = 1'b0;
                if (!s.cfg_unified && ihit) begin
                  next_s.ivalid[li] = 1'b0;
                end
                next_s.state = ST_FIN;
              end
            end
            OP_ISYNC: next_s.state = ST_SYNC;
            default: begin
              next_s.noop = 1'b1;
              next_s.done = 1'b1;
              next_s.state = ST_IDLE;
            end
          endcase
        end
      end
      ST_WB: if (bus_ack) begin
        next_s.breq = 1'b0;
        next_s.dmod[li] = 1'b0;
        if (s.op == OP_ZERO) begin
          next_s.dvalid[li] = 1'b1;
          next_s.dtag[li] = tg;
          next_s.ddata[li] = '0;
          next_s.dmod[li] = 1'b1;
        end else if (s.op == OP_FLUSH) begin
          next_s.dvalid[li] = 1'b0;
        end
        next_s.state = ST_FIN;
      end
      ST_FILL: if (bus_ack) begin
        next_s.breq = 1'b0;
        next_s.dvalid[li] = 1'b1;
        next_s.dtag[li] = tg;
        next_s.ddata[li] = bus_rdata;
        next_s.dmod[li] = 1'b0;
        next_s.state = ST_FIN;
      end
      ST_ZMEM: if (bus_ack) begin
        next_s.breq = 1'b0;
        next_s.state = ST_FIN;
      end
      ST_FIN: begin
        // remote caches are told before done is reported
        if (s.coh && needs_snoop(s.op)) begin
          next_s.breq = 1'b1;
          next_s.bcmd = snoop_cmd(s.op);
          next_s.baddr = tgt_addr;
          next_s.state = ST_SNOOP;
        end else begin
          next_s.done = 1'b1;
          next_s.state = ST_IDLE;
        end
      end
      ST_SNOOP: if (bus_ack) begin
        next_s.breq = 1'b0;
        next_s.done = 1'b1;
        next_s.state = ST_IDLE;
      end
      ST_SYNC: if (pipe_idle) begin
        next_s.discard = 1'b1;
        next_s.done = 1'b1;
        next_s.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.rdata;
  assign pslverr = s.slverr;
  assign pready = psel && penable;
  assign bus_req = s.breq;
  assign bus_cmd = s.bcmd;
  assign bus_addr = s.baddr;
  assign bus_wdata = s.bwdata;
  // hold covers the whole wait so no later instruction slips in
  assign fetch_hold = (s.state == ST_SYNC);
  assign fetch_discard = s.discard;
endmodule
`default_nettype wire

// *** sim/cbm_unit_assertions.sv ***
// port checker for the cache block unit
`timescale 1ns/10ps
`default_nettype none
module cbm_unit_assertions (
  input wire logic                        clk_sys,
  input wire logic                        rst,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic [cbm_pkg::PADDR_W-1:0] paddr,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        bus_req,
  input wire logic                        bus_ack,
  input wire logic [cbm_pkg::BCMD_W-1:0]  bus_cmd,
  input wire logic [cbm_pkg::ADDR_W-1:0]  bus_addr,
  input wire logic [cbm_pkg::BLK_W-1:0]   bus_wdata,
  input wire logic                        pipe_idle,
  input wire logic                        fetch_hold,
  input wire logic                        fetch_discard
);
  import cbm_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_req_open;
    bus_req && !bus_ack;
  endsequence
  sequence s_req_done;
    bus_req && bus_ack;
  endsequence
  a_ready_zero_wait: assert property (psel && penable |-> pready)
    else $error("no pready in access");
  a_req_held: assert property (s_req_open |=> bus_req && $stable(bus_cmd) && $stable(bus_addr)
    && $stable(bus_wdata)) else $error("request changed before ack");
  a_req_release: assert property (s_req_done |=> !bus_req)
    else $error("request held after ack");
  a_addr_aligned: assert property (bus_req |-> bus_addr[3:0] == 4'h0)
    else $error("address not aligned");
  a_sync_waits: assert property (fetch_hold && !pipe_idle |=> fetch_hold)
    else $error("hold dropped early");
  a_sync_discard: assert property (fetch_hold && pipe_idle |=> ##[0:1] fetch_discard)
    else $error("no discard after sync");
  a_discard_pulse: assert property (fetch_discard |=> !fetch_discard)
    else $error("discard too long");
  a_sync_quiet: assert property (fetch_hold |-> !bus_req)
    else $error("bus busy in sync");
  a_err_unmapped: assert property (psel && penable && paddr > 8'h1C |-> pslverr)
    else $error("no error when unmapped");
endmodule
bind cbm_unit cbm_unit_assertions u_chk (.clk_sys, .rst, .psel, .penable, .paddr, .pready,
  .pslverr, .bus_req, .bus_ack, .bus_cmd, .bus_addr, .bus_wdata, .pipe_idle, .fetch_hold,
  .fetch_discard);
`default_nettype wire

// *** sim/cbm_far_model.sv ***
// far side model: memory and the other processors' caches
`timescale 1ns/10ps
`default_nettype none
module cbm_far_model (
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic                       bus_req,
  input  wire logic [cbm_pkg::BCMD_W-1:0] bus_cmd,
  input  wire logic [cbm_pkg::ADDR_W-1:0] bus_addr,
  input  wire logic [cbm_pkg::BLK_W-1:0]  bus_wdata,
  input  wire logic [7:0]                 slow,
  output logic                            bus_ack,
  output logic      [cbm_pkg::BLK_W-1:0]  bus_rdata,
  output int                              n_req,
  output logic      [cbm_pkg::BCMD_W-1:0] last_cmd,
  output logic      [cbm_pkg::ADDR_W-1:0] last_addr,
  output logic      [cbm_pkg::BLK_W-1:0]  last_wdata
);
  import cbm_pkg::*;
  logic [7:0] cnt;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_ack <= 1'b0;
      bus_rdata <= '0;
      cnt <= 8'h00;
      n_req <= 0;
      last_cmd <= '0;
      last_addr <= '0;
      last_wdata <= '0;
    end else begin
      bus_ack <= 1'b0;
      // toggling exposes a stale fill sample
      bus_rdata <= ~bus_rdata;
      if (bus_req && !bus_ack) begin
        if (cnt >= slow) begin
          // remote caches settle in one reply
          bus_ack <= 1'b1;
          bus_rdata <= {4{~bus_addr}};
          n_req <= n_req + 1;
          last_cmd <= bus_cmd;
          last_addr <= bus_addr;
          last_wdata <= bus_wdata;
          cnt <= 8'h00;
        end else begin
          cnt <= cnt + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** sim/tb_cbm_unit.sv ***
// self-checking bench for the cache block maintenance unit
`timescale 1ns/10ps
`default_nettype none
module tb_cbm_unit;
  import cbm_pkg::*;
  localparam logic [31:0] C = 1 << CMD_COH, I = 1 << CMD_CI, W = 1 << CMD_WT;
  localparam logic [31:0] D = 1 << CMD_DSTORE, L = 1 << CMD_LOAD_OK;
  localparam logic [31:0] S = 1 << CMD_STORE_OK, EA = 32'h0000_1234;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, err;
  logic bus_req, bus_ack, pipe_idle, fetch_hold, fetch_discard;
  logic [PADDR_W-1:0] paddr;
  logic [DATA_W-1:0]  pwdata, prdata, q;
  logic [BCMD_W-1:0]  bus_cmd, last_cmd;
  logic [ADDR_W-1:0]  bus_addr, last_addr;
  logic [BLK_W-1:0]   bus_wdata, bus_rdata, last_wdata;
  logic [7:0]         slow;
  int                 n_req, n0, failures, samples_checked;
  cbm_unit dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .bus_req, .bus_cmd, .bus_addr, .bus_wdata, .bus_rdata, .bus_ack, .pipe_idle,
    .fetch_hold, .fetch_discard);
  cbm_far_model u_far (.clk_sys, .rst, .bus_req, .bus_cmd, .bus_addr, .bus_wdata, .slow,
    .bus_ack, .bus_rdata, .n_req, .last_cmd, .last_addr, .last_wdata);
  function automatic logic [31:0] cm(input logic [OP_W-1:0] o, input logic [31:0] f);
    return {29'h0, o} | f;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // starts just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    apb(1'b0, a, '0);
    chk(nm, e, q & m);
  endtask
  task automatic op(input logic [31:0] cmd, input logic [31:0] ea);
    apb(1'b1, REG_ADDR, ea);
    apb(1'b1, REG_CMD, cmd);
    do apb(1'b0, REG_STATUS, '0); while (q[STAT_DONE] !== 1'b1);
    q = q & 32'h1F;
  endtask
  task automatic t_basic;
    rc("cfg", REG_CFG, '1, '0);
    apb(1'b0, 8'h20, '0);
    chk("unmapped", 32'h1, {q[30:0], err});
    n0 = n_req;
    op(cm(OP_TOUCH, D | L), EA);
    chk("dst_touch", 32'h12, q);
    op(cm(OP_ZERO, D | S | C), EA);
    chk("dst_zero", 32'h12, q);
    chk("dst_bus", n0, n_req);
    $display("basic done");
  endtask
  task automatic t_touch;
    apb(1'b1, REG_CFG, 1 << CFG_PF);
    apb(1'b1, REG_HIST, '0);
    op(cm(OP_TOUCH_ST, '0), EA);
    chk("touch_bad", 32'h12, q);
    chk("touch_bus", n0, n_req);
    op(cm(OP_TOUCH, L), EA);
    chk("touch_st", 32'h2, q);
    chk("touch_cmd", 32'(BUS_READ), 32'(last_cmd));
    chk("touch_adr", 32'h1230, last_addr);
    apb(1'b1, REG_PROBE, 32'hC);
    rc("fill", REG_PDATA, '1, ~32'h1230);
    rc("hist", REG_HIST, 32'h7, 32'h1);
    $display("touch done");
  endtask
  task automatic t_zero;
    apb(1'b1, REG_HIST, '0);
    slow <= 8'h05;
    op(cm(OP_ZERO, C | L | S), EA);
    chk("zero_cmd", 32'(BUS_SNP_KILL), 32'(last_cmd));
    rc("zero_data", REG_PDATA, '1, '0);
    rc("zero_tag", REG_PTAG, 32'h7FFFFFFF, 32'h3000_0048);
    rc("zero_hist", REG_HIST, 32'h7, 32'h7);
    slow <= 8'h00;
    op(cm(OP_ZERO, L), EA);
    chk("zero_dsi", 32'h0A, q);
    n0 = n_req;
    op(cm(OP_ZERO, L | S), 32'h20);
    chk("alloc_bus", n0, n_req);
    apb(1'b1, REG_PROBE, 32'h8);
    rc("alloc_tag", REG_PTAG, 32'h7FFFFFFF, 32'h3000_0000);
    apb(1'b1, REG_CFG, '0);
    op(cm(OP_ZERO, I | L | S), 32'h2000);
    chk("ci_align", 32'h06, q);
    apb(1'b1, REG_CFG, 1 << CFG_ZMEM);
    op(cm(OP_ZERO, I | L | S), 32'h2000);
    chk("ci_cmd", 32'(BUS_ZERO), 32'(last_cmd));
    $display("zero done");
  endtask
  task automatic t_flush;
    n0 = n_req;
    apb(1'b1, REG_PROBE, 32'hC);
    op(cm(OP_STORE, L), EA);
    chk("st_cmd", 32'(BUS_WRITE), 32'(last_cmd));
    chk("st_data", '0, last_wdata[31:0]);
    rc("st_tag", REG_PTAG, 32'h7FFFFFFF, 32'h1000_0048);
    apb(1'b1, REG_HIST, '0);
    op(cm(OP_FLUSH, C | I | W | L), EA);
    chk("fl_cmd", 32'(BUS_SNP_FLUSH), 32'(last_cmd));
    chk("fl_bus", n0 + 2, n_req);
    rc("fl_tag", REG_PTAG, 32'h3000_0000, '0);
    rc("fl_hist", REG_HIST, 32'h7, 32'h1);
    op(cm(OP_FLUSH, L), EA);
    chk("fl_miss", n0 + 2, n_req);
    $display("flush done");
  endtask
  task automatic t_sync;
    op(cm(OP_IINV, C), EA);
    chk("ii_dsi", 32'h0A, q);
    apb(1'b1, REG_CFG, 1 << CFG_UNIFIED);
    op(cm(OP_IINV, C | L), EA);
    chk("ii_cmd", 32'(BUS_SNP_IINV), 32'(last_cmd));
    n0 = n_req;
    pipe_idle <= 1'b0;
    apb(1'b1, REG_CMD, cm(OP_ISYNC, '0));
    repeat (8) @(posedge clk_sys);
    chk("hold", 32'h1, 32'(fetch_hold));
    rc("sync_busy", REG_STATUS, 32'h2, '0);
    pipe_idle <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("discard", 32'h1, 32'(fetch_discard));
    do apb(1'b0, REG_STATUS, '0); while (q[STAT_DONE] !== 1'b1);
    chk("sync_bus", n0, n_req);
    $display("sync done");
  endtask
  task automatic test_done;
    $display("compared %0d mismatched %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (8000) @(posedge clk_sys);
    failures++;
    test_done;
  end
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    pipe_idle = 1'b1; slow = 8'h00; failures = 0; samples_checked = 0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_basic;
    t_touch;
    t_zero;
    t_flush;
    t_sync;
    test_done;
  end
endmodule
`default_nettype wire
